// ===== pad_function_select_regs.svh
// constants for the pad function multiplexer
`ifndef PAD_FUNCTION_SELECT_REGS_SVH
`define PAD_FUNCTION_SELECT_REGS_SVH

// pad count and pad index within the pad vectors
`define PAD_COUNT 7
`define PAD_A4 0
`define PAD_A5 1
`define PAD_A6 2
`define PAD_D4 3
`define PAD_E0 4
`define PAD_E1 5
`define PAD_B1 6

// configuration field positions
`define CFG_A4_HI 3
`define CFG_A4_LO 0
`define CFG_A5_HI 7
`define CFG_A5_LO 4
`define CFG_A6_HI 11
`define CFG_A6_LO 8
`define CFG_D4_HI 3
`define CFG_D4_LO 0
`define CFG_E0_HI 3
`define CFG_E0_LO 0
`define CFG_E1_HI 7
`define CFG_E1_LO 4
`define CFG_B1_HI 7
`define CFG_B1_LO 4

// pad configuration field codes
`define CFG_ANALOG 4'h0
`define CFG_OUT_PUSH_PULL 4'h1
`define CFG_INPUT 4'h4
`define CFG_OUT_OPEN_DRAIN 4'h5
`define CFG_INPUT_PULL 4'h8
`define CFG_ALT_OUT 4'h9
`define CFG_ALT_OPEN_DRAIN 4'hd

// control bit positions in peripheral config words
`define UART_RTS_EN_BIT 5
`define SPI_SLAVE_BIT 4
`define TIMER2_REMAP_CH1_BIT 4

// reset values
`define BOOT_MONITOR_RESET 1'b0
`define PAD_OE_N_RESET 7'h7f

// cycles after external reset release during which the boot pin is still sampled
`define BOOT_HOLD_CYCLES 3'h4

`endif

// ===== pad_function_select_pkg.sv
// types for the pad function multiplexer
`default_nettype none
package pad_function_select_pkg;

  // serial controller operating mode
  typedef enum logic [1:0] {
    mode_off_type_v = 2'h0,
    mode_uart = 2'h1,
    mode_spi = 2'h2,
    mode_two_wire = 2'h3
  } ctrl_mode_type;

  // trace control from the cpu and software
  typedef struct packed {
    logic trace_enable;
    logic trace_four_wire;
    logic packet_trace_enable;
  } trace_ctrl_type;

  // signals that peripherals offer to the pads
  typedef struct packed {
    logic packet_trace_frame;
    logic packet_trace_serial_data;
    logic cpu_trace_bit2;
    logic cpu_trace_bit3;
    logic ctrl3_request_to_send_n;
    logic ctrl4_master_out_line;
    logic ctrl4_master_in_line;
    logic ctrl4_two_wire_data;
    logic ctrl1_master_in_line;
    logic ctrl1_master_out_line;
    logic ctrl1_two_wire_data;
    logic ctrl1_uart_transmit;
    logic timer1_channel3_pin;
    logic timer2_channel1_pin;
  } periph_out_type;

  // signals that the pads hand to peripherals
  typedef struct packed {
    logic ctrl3_slave_select_n;
    logic ctrl4_master_out_line;
    logic ctrl4_master_in_line;
    logic ctrl4_two_wire_data;
    logic ctrl1_two_wire_data;
    logic timer1_channel3_pin;
    logic timer2_channel1_pin;
  } periph_in_type;

endpackage
`default_nettype wire

// ===== pad_function_select.sv
// pad function multiplexer for seven digital pads
`include "pad_function_select_regs.svh"
`default_nettype none
module pad_function_select (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`PAD_COUNT-1:0] pad_in,
  output logic [`PAD_COUNT-1:0] pad_out,
  output logic [`PAD_COUNT-1:0] pad_oe_n,
  input wire logic [11:0] port_a_high_pad_config,
  input wire logic [7:4] port_b_low_pad_config,
  input wire logic [3:0] port_d_high_pad_config,
  input wire logic [7:0] port_e_low_pad_config,
  input wire pad_function_select_pkg::trace_ctrl_type trace_ctrl,
  input wire pad_function_select_pkg::ctrl_mode_type ctrl1_mode_select,
  input wire pad_function_select_pkg::ctrl_mode_type ctrl3_mode_select,
  input wire pad_function_select_pkg::ctrl_mode_type ctrl4_mode_select,
  input wire logic [7:0] ctrl1_spi_config,
  input wire logic [7:0] ctrl3_spi_config,
  input wire logic [7:0] ctrl3_uart_config,
  input wire logic [7:0] ctrl4_spi_config,
  input wire logic timer1_channel_output_enable,
  input wire logic timer2_channel_output_enable,
  input wire logic [7:0] timer2_pin_remap,
  input wire pad_function_select_pkg::periph_out_type periph_out,
  output pad_function_select_pkg::periph_in_type periph_in,
  input wire logic [`PAD_COUNT-1:0] gpio_out,
  output logic [`PAD_COUNT-1:0] gpio_in,
  output logic analog_input_four,
  output logic analog_input_five,
  input wire logic [2:0] ext_irq_c_pin_select,
  input wire logic [2:0] ext_irq_d_pin_select,
  output logic external_interrupt_c,
  output logic external_interrupt_d,
  input wire logic external_reset_n,
  output logic boot_to_monitor
);
  import pad_function_select_pkg::*;

  // field decoders; the drive ones are shared by all pads, the analog one serves only the two port-A high pads
  // codes outside the decoded set leave the pad undriven, like an input
  // open drain is shared by the gpio and the alternate open-drain codes
  function automatic logic cfg_is_analog(input logic [3:0] cfg);
    cfg_is_analog = (cfg == `CFG_ANALOG);
  endfunction

  function automatic logic cfg_is_alt(input logic [3:0] cfg);
    cfg_is_alt = (cfg == `CFG_ALT_OUT) || (cfg == `CFG_ALT_OPEN_DRAIN);
  endfunction

  function automatic logic cfg_is_open_drain(input logic [3:0] cfg);
    cfg_is_open_drain = (cfg == `CFG_ALT_OPEN_DRAIN) || (cfg == `CFG_OUT_OPEN_DRAIN);
  endfunction

  function automatic logic cfg_is_gpio_out(input logic [3:0] cfg);
    cfg_is_gpio_out = (cfg == `CFG_OUT_PUSH_PULL) || (cfg == `CFG_OUT_OPEN_DRAIN);
  endfunction

  // pad input synchroniser, second stage is the only reader of the first
  // every pad level and the external reset pin arrive from outside the clock
  logic [`PAD_COUNT-1:0] pad_meta;
  logic [`PAD_COUNT-1:0] pad_sync;
  logic ext_reset_meta;
  logic ext_reset_sync;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_meta <= '0;
      pad_sync <= '0;
      ext_reset_meta <= 1'b0;
      ext_reset_sync <= 1'b0;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
      ext_reset_meta <= external_reset_n;
      ext_reset_sync <= ext_reset_meta;
    end
  end

  // per-pad configuration fields
  logic [3:0] pad_cfg [`PAD_COUNT];
  assign pad_cfg[`PAD_A4] = port_a_high_pad_config[`CFG_A4_HI:`CFG_A4_LO];
  assign pad_cfg[`PAD_A5] = port_a_high_pad_config[`CFG_A5_HI:`CFG_A5_LO];
  assign pad_cfg[`PAD_A6] = port_a_high_pad_config[`CFG_A6_HI:`CFG_A6_LO];
  assign pad_cfg[`PAD_D4] = port_d_high_pad_config[`CFG_D4_HI:`CFG_D4_LO];
  assign pad_cfg[`PAD_E0] = port_e_low_pad_config[`CFG_E0_HI:`CFG_E0_LO];
  assign pad_cfg[`PAD_E1] = port_e_low_pad_config[`CFG_E1_HI:`CFG_E1_LO];
  assign pad_cfg[`PAD_B1] = port_b_low_pad_config[`CFG_B1_HI:`CFG_B1_LO];

  // peripheral role decode
  // the spi role bit only counts while the controller is in spi mode
  // timer 2 takes the port-B pad only when remapped and its output enabled
  wire packet_trace_on = !trace_ctrl.trace_enable && trace_ctrl.packet_trace_enable;
  wire cpu_trace_on = trace_ctrl.trace_enable && trace_ctrl.trace_four_wire;
  wire ctrl1_spi = (ctrl1_mode_select == mode_spi);
  wire ctrl1_slave = ctrl1_spi_config[`SPI_SLAVE_BIT];
  wire ctrl3_spi_slave = (ctrl3_mode_select == mode_spi) && ctrl3_spi_config[`SPI_SLAVE_BIT];
  wire ctrl3_rts_on = (ctrl3_mode_select == mode_uart) && ctrl3_uart_config[`UART_RTS_EN_BIT];
  wire ctrl4_spi = (ctrl4_mode_select == mode_spi);
  wire ctrl4_slave = ctrl4_spi_config[`SPI_SLAVE_BIT];
  wire timer2_remap = timer2_pin_remap[`TIMER2_REMAP_CH1_BIT];
  wire timer2_claims_b1 = timer2_remap && timer2_channel_output_enable;
  wire ctrl1_owns_b1 = !timer2_channel_output_enable || !timer2_remap;

  // alternate source per pad: whether one is active and its level
  // an alternate code with no active source drives the pad low
  logic [`PAD_COUNT-1:0] alt_ok;
  logic [`PAD_COUNT-1:0] alt_val;

  // first port-A high pad: cpu trace takes it over packet trace
  assign alt_ok[`PAD_A4] = cpu_trace_on || packet_trace_on;
  assign alt_val[`PAD_A4] = cpu_trace_on ? periph_out.cpu_trace_bit2
                                         : periph_out.packet_trace_frame;

  // second port-A high pad
  assign alt_ok[`PAD_A5] = cpu_trace_on || packet_trace_on;
  assign alt_val[`PAD_A5] = cpu_trace_on ? periph_out.cpu_trace_bit3
                                         : periph_out.packet_trace_serial_data;

  // high-current pad carries timer 1 channel 3
  assign alt_ok[`PAD_A6] = timer1_channel_output_enable;
  assign alt_val[`PAD_A6] = periph_out.timer1_channel3_pin;

  // port-D pad carries controller 3 request-to-send
  assign alt_ok[`PAD_D4] = ctrl3_rts_on;
  assign alt_val[`PAD_D4] = periph_out.ctrl3_request_to_send_n;

  // first port-E pad: controller 4 master data out
  assign alt_ok[`PAD_E0] = ctrl4_spi && !ctrl4_slave;
  assign alt_val[`PAD_E0] = periph_out.ctrl4_master_out_line;

  // second port-E pad: two-wire data or spi slave data out
  wire e1_two_wire = (ctrl4_mode_select == mode_two_wire);
  assign alt_ok[`PAD_E1] = e1_two_wire || (ctrl4_spi && ctrl4_slave);
  assign alt_val[`PAD_E1] = e1_two_wire ? periph_out.ctrl4_two_wire_data
                                        : periph_out.ctrl4_master_in_line;

  // port-B pad: timer 2 when remapped and enabled, else controller 1
  // controller 1 picks its line by mode, and by role bit in spi mode
  // an idle controller offers nothing, so the pad is driven low
  logic b1_ctrl1_ok;
  logic b1_ctrl1_val;
  always_comb begin
    b1_ctrl1_ok = 1'b0;
    b1_ctrl1_val = 1'b0;
    unique case (ctrl1_mode_select)
      mode_spi: begin
        b1_ctrl1_ok = 1'b1;
        b1_ctrl1_val = ctrl1_slave ? periph_out.ctrl1_master_in_line
                                   : periph_out.ctrl1_master_out_line;
      end
      mode_two_wire: begin
        b1_ctrl1_ok = 1'b1;
        b1_ctrl1_val = periph_out.ctrl1_two_wire_data;
      end
      mode_uart: begin
        b1_ctrl1_ok = 1'b1;
        b1_ctrl1_val = periph_out.ctrl1_uart_transmit;
      end
      mode_off_type_v: begin
        b1_ctrl1_ok = 1'b0;
        b1_ctrl1_val = 1'b0;
      end
    endcase
  end
  assign alt_ok[`PAD_B1] = timer2_claims_b1 || (ctrl1_owns_b1 && b1_ctrl1_ok);
  assign alt_val[`PAD_B1] = timer2_claims_b1 ? periph_out.timer2_channel1_pin
                                             : b1_ctrl1_val;

  // per-pad output resolution: analog, alternate, plain gpio or idle
  // analog and input codes release the pad and drive it low inside
  // one copy of this resolution per pad, indexed by the pad constants
  logic [`PAD_COUNT-1:0] next_pad_out;
  logic [`PAD_COUNT-1:0] next_pad_oe_n;
  genvar g;
  generate
    for (g = 0; g < `PAD_COUNT; g++) begin : g_pad
      wire is_alt = cfg_is_alt(pad_cfg[g]);
      wire is_od = cfg_is_open_drain(pad_cfg[g]);
      wire is_gpio = cfg_is_gpio_out(pad_cfg[g]);
      wire drv_val = is_alt ? (alt_ok[g] & alt_val[g]) : gpio_out[g];
      wire drv_on = is_alt || is_gpio;
      // open drain pulls low only, push-pull always drives
      assign next_pad_out[g] = drv_on ? drv_val : 1'b0;
      assign next_pad_oe_n[g] = !(drv_on && (!is_od || !drv_val));
    end
  endgenerate

  // peripheral inputs taken from the pads
  // unselected inputs show their idle level: select and two-wire high
  periph_in_type next_periph_in;
  always_comb begin
    next_periph_in.ctrl3_slave_select_n = ctrl3_spi_slave ? pad_sync[`PAD_D4]
                                                          : 1'b1;
    next_periph_in.ctrl4_master_out_line = (ctrl4_spi && ctrl4_slave) ? pad_sync[`PAD_E0]
                                                                      : 1'b0;
    next_periph_in.ctrl4_master_in_line = (ctrl4_spi && !ctrl4_slave) ? pad_sync[`PAD_E1]
                                                                      : 1'b0;
    next_periph_in.ctrl4_two_wire_data = e1_two_wire ? pad_sync[`PAD_E1] : 1'b1;
    next_periph_in.ctrl1_two_wire_data =
      (ctrl1_owns_b1 && ctrl1_mode_select == mode_two_wire) ? pad_sync[`PAD_B1]
                                                            : 1'b1;
    next_periph_in.timer1_channel3_pin = pad_sync[`PAD_A6];
    // timer 2 channel 1 listens on the port-B pad while not remapped
    next_periph_in.timer2_channel1_pin = !timer2_remap ? pad_sync[`PAD_B1] : 1'b0;
  end

  // analog connection of the two port-A high pads
  // the converter join is a level that follows the field alone
  wire next_analog_four = cfg_is_analog(pad_cfg[`PAD_A4]);
  wire next_analog_five = cfg_is_analog(pad_cfg[`PAD_A5]);

  // pick one synchronised pad level by index, out of range reads as low
  // the selector never indexes the vector itself, so no unknown escapes
  function automatic logic pad_pick(input logic [`PAD_COUNT-1:0] lvl,
                                    input logic [2:0] sel);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `PAD_COUNT; i++) begin
      if (sel == 3'(i)) begin
        hit = lvl[i];
      end
    end
    pad_pick = hit;
  endfunction

  // external interrupt pin selection, out of range selects nothing
  wire next_irq_c = pad_pick(pad_sync, ext_irq_c_pin_select);
  wire next_irq_d = pad_pick(pad_sync, ext_irq_d_pin_select);

  // pad drive registers, all pads released while in reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_out <= '0;
      pad_oe_n <= `PAD_OE_N_RESET;
    end else begin
      pad_out <= next_pad_out;
      pad_oe_n <= next_pad_oe_n;
    end
  end

  // peripheral input registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      periph_in <= '0;
    end else begin
      periph_in <= next_periph_in;
    end
  end

  // plain gpio input registers, fed from the synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gpio_in <= '0;
    end else begin
      gpio_in <= pad_sync;
    end
  end

  // analog join registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_input_four <= 1'b0;
      analog_input_five <= 1'b0;
    end else begin
      analog_input_four <= next_analog_four;
      analog_input_five <= next_analog_five;
    end
  end

  // interrupt level outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      external_interrupt_c <= 1'b0;
      external_interrupt_d <= 1'b0;
    end else begin
      external_interrupt_c <= next_irq_c;
      external_interrupt_d <= next_irq_d;
    end
  end

  // boot select window: open while external reset low and a few cycles after
  // the hold keeps the window open four cycles past the synchronised release, so a boot
  // pin released together with reset decides by its new level; then the choice freezes
  logic [2:0] boot_hold;
  wire boot_window = !ext_reset_sync || (boot_hold != 3'h0);
  wire [2:0] next_boot_hold = !ext_reset_sync ? `BOOT_HOLD_CYCLES
                            : (boot_hold != 3'h0) ? boot_hold - 3'h1 : 3'h0;
  wire next_boot = boot_window ? !pad_sync[`PAD_A5] : boot_to_monitor;

  // window counter, reloaded while external reset is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_hold <= 3'h0;
    end else begin
      boot_hold <= next_boot_hold;
    end
  end

  // boot decision register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_to_monitor <= `BOOT_MONITOR_RESET;
    end else begin
      boot_to_monitor <= next_boot;
    end
  end

endmodule // pad_function_select
`default_nettype wire

// ===== pad_function_select_asserts.sv
// port-level checks for the pad function multiplexer
`default_nettype none
module pad_function_select_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [6:0] pad_in,
  input wire logic [6:0] pad_out,
  input wire logic [6:0] pad_oe_n,
  input wire logic [11:0] port_a_high_pad_config,
  input wire logic [7:4] port_b_low_pad_config,
  input wire logic [3:0] port_d_high_pad_config,
  input wire logic [7:0] port_e_low_pad_config,
  input wire pad_function_select_pkg::trace_ctrl_type trace_ctrl,
  input wire pad_function_select_pkg::ctrl_mode_type ctrl1_mode_select,
  input wire pad_function_select_pkg::ctrl_mode_type ctrl3_mode_select,
  input wire pad_function_select_pkg::ctrl_mode_type ctrl4_mode_select,
  input wire logic [7:0] ctrl3_uart_config,
  input wire logic [7:0] ctrl4_spi_config,
  input wire logic timer1_channel_output_enable,
  input wire logic timer2_channel_output_enable,
  input wire logic [7:0] timer2_pin_remap,
  input wire pad_function_select_pkg::periph_out_type periph_out,
  input wire pad_function_select_pkg::periph_in_type periph_in,
  input wire logic analog_input_four,
  input wire logic analog_input_five
);
  import pad_function_select_pkg::*;
  // outputs follow the selecting inputs one edge later; the timer 1 input follows its pad three edges later
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_analog_four: assert property (
    port_a_high_pad_config[3:0] == 4'h0 |=> analog_input_four) else $error("a4 not analog");
  a_packet_frame: assert property (
    port_a_high_pad_config[3:0] == 4'h9 && !trace_ctrl.trace_enable
    && trace_ctrl.packet_trace_enable |=> !pad_oe_n[0]
    && pad_out[0] == $past(periph_out.packet_trace_frame)) else $error("a4 frame");
  a_trace_bit2: assert property (
    port_a_high_pad_config[3:0] == 4'h9 && trace_ctrl.trace_enable && trace_ctrl.trace_four_wire
    |=> !pad_oe_n[0] && pad_out[0] == $past(periph_out.cpu_trace_bit2)) else $error("a4 trace");
  a_analog_five: assert property (
    port_a_high_pad_config[7:4] == 4'h0 |=> analog_input_five) else $error("a5 not analog");
  a_rts_drive: assert property (
    port_d_high_pad_config == 4'h9 && ctrl3_uart_config[5] && ctrl3_mode_select == mode_uart
    |=> !pad_oe_n[3] && pad_out[3] == $past(periph_out.ctrl3_request_to_send_n))
    else $error("d4 rts");
  a_mosi4_drive: assert property (
    port_e_low_pad_config[3:0] == 4'h9 && ctrl4_mode_select == mode_spi && !ctrl4_spi_config[4]
    |=> !pad_oe_n[4] && pad_out[4] == $past(periph_out.ctrl4_master_out_line))
    else $error("e0 mosi");
  a_tim1_drive: assert property (
    port_a_high_pad_config[11:8] == 4'h9 && timer1_channel_output_enable
    |=> !pad_oe_n[2] && pad_out[2] == $past(periph_out.timer1_channel3_pin)) else $error("a6");
  a_tim1_input: assert property (
    pad_in[2] [*4] |-> periph_in.timer1_channel3_pin) else $error("a6 input");
  a_tim2_drive: assert property (
    port_b_low_pad_config == 4'h9 && timer2_pin_remap[4] && timer2_channel_output_enable
    |=> !pad_oe_n[6] && pad_out[6] == $past(periph_out.timer2_channel1_pin)) else $error("b1");
  a_uart_drive: assert property (
    port_b_low_pad_config == 4'h9 && !(timer2_pin_remap[4] && timer2_channel_output_enable)
    && ctrl1_mode_select == mode_uart |=> !pad_oe_n[6]
    && pad_out[6] == $past(periph_out.ctrl1_uart_transmit)) else $error("b1 uart");
  // main scenarios reached
  c_trace: cover property (trace_ctrl.trace_four_wire && !pad_oe_n[0]);
  c_analog: cover property (analog_input_five);
  c_remap: cover property (timer2_pin_remap[4] && !pad_oe_n[6]);
endmodule // pad_function_select_asserts
bind pad_function_select pad_function_select_asserts chk (.*);
`default_nettype wire

// ===== pad_far_side.sv
// external devices on the seven pads, resolving each pad level
`default_nettype none
module pad_far_side (
  input wire logic clk,
  input wire logic [6:0] pad_out,
  input wire logic [6:0] pad_oe_n,
  input wire logic [6:0] ext_en,
  input wire logic [6:0] ext_val,
  input wire logic [6:0] pull_up,
  output logic [6:0] pad_level
);
  logic [6:0] last = 7'h00;
  // remember levels so a floating pad can show their inverse
  always_ff @(posedge clk) last <= pad_level;
  // wired level: low wins, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (!pad_oe_n[i] && ext_en[i]) pad_level[i] = pad_out[i] & ext_val[i];
      else if (!pad_oe_n[i]) pad_level[i] = pad_out[i];
      else if (ext_en[i]) pad_level[i] = ext_val[i];
      else if (pull_up[i]) pad_level[i] = 1'b1;
      else pad_level[i] = ~last[i];
    end
  end
endmodule // pad_far_side
`default_nettype wire

// ===== pad_function_select_tb.sv
// self-checking bench for the pad function multiplexer
`default_nettype none
module pad_function_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pad_function_select_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, external_reset_n = 1'b1;
  logic timer1_channel_output_enable = 1'b0, timer2_channel_output_enable = 1'b0;
  logic [6:0] pad_in, pad_out, pad_oe_n, gpio_in, gpio_out = 7'h00;
  logic [6:0] ext_en = 7'h7f, ext_val = 7'h00;
  logic [11:0] port_a_high_pad_config = 12'h444;
  logic [3:0] port_b_low_pad_config = 4'h4, port_d_high_pad_config = 4'h4;
  logic [7:0] port_e_low_pad_config = 8'h44, timer2_pin_remap = 8'h00;
  logic [7:0] ctrl1_spi_config = 8'h00, ctrl3_spi_config = 8'h00;
  logic [7:0] ctrl3_uart_config = 8'h00, ctrl4_spi_config = 8'h00;
  logic [2:0] ext_irq_c_pin_select = 3'h7, ext_irq_d_pin_select = 3'h7;
  logic analog_input_four, analog_input_five, external_interrupt_c, external_interrupt_d;
  logic boot_to_monitor;
  trace_ctrl_type trace_ctrl = '0;
  ctrl_mode_type ctrl1_mode_select = mode_off_type_v, ctrl3_mode_select = mode_off_type_v;
  ctrl_mode_type ctrl4_mode_select = mode_off_type_v;
  periph_out_type periph_out = '0;
  periph_in_type periph_in;
  int fail_count = 0, check_count = 0;
  // design and the devices on its pads
  pad_function_select DUT (.*);
  pad_far_side far (.clk, .pad_out, .pad_oe_n, .ext_en, .ext_val, .pull_up(7'h60),
    .pad_level(pad_in));
  always #5 clk = ~clk;
  // wait edges, then act just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_trace_pads;
    port_a_high_pad_config[7:0] = 8'h00;
    step(2);
    chk({analog_input_four, analog_input_five}, 2'h3);
    port_a_high_pad_config[7:0] = 8'h99;
    trace_ctrl = 3'h1;
    periph_out.packet_trace_frame = 1'b1;
    step(2);
    chk({analog_input_four, pad_oe_n[1:0], pad_out[1:0]}, 5'h01);
    trace_ctrl = 3'h5;
    step(2);
    chk({pad_oe_n[1:0], pad_out[1:0]}, 4'h0);
    trace_ctrl = 3'h7;
    periph_out.cpu_trace_bit3 = 1'b1;
    step(2);
    chk({pad_oe_n[1:0], pad_out[1:0]}, 4'h2);
    port_a_high_pad_config[7:0] = 8'h11;
    gpio_out[1:0] = 2'h1;
    step(2);
    chk({pad_oe_n[1:0], pad_out[1:0]}, 4'h1);
    port_a_high_pad_config[7:0] = 8'h44;
    ext_val[1:0] = 2'h2;
    step(4);
    chk({pad_oe_n[1:0], gpio_in[1:0]}, 4'he);
  endtask
  task automatic t_ctrl3;
    ctrl3_mode_select = mode_uart;
    ctrl3_uart_config = 8'h20;
    port_d_high_pad_config = 4'h9;
    periph_out.ctrl3_request_to_send_n = 1'b1;
    step(2);
    chk({pad_oe_n[3], pad_out[3]}, 2'h1);
    ctrl3_uart_config = 8'hdf;
    step(2);
    chk({pad_oe_n[3], pad_out[3]}, 2'h0);
    ctrl3_mode_select = mode_spi;
    ctrl3_spi_config = 8'h10;
    port_d_high_pad_config = 4'h4;
    ext_val[3] = 1'b0;
    step(4);
    chk(periph_in.ctrl3_slave_select_n, 1'b0);
    ctrl3_spi_config = 8'h00;
    step(4);
    chk(periph_in.ctrl3_slave_select_n, 1'b1);
  endtask
  task automatic t_ctrl4;
    ctrl4_mode_select = mode_spi;
    port_e_low_pad_config = 8'h49;
    periph_out.ctrl4_master_out_line = 1'b1;
    ext_val[5:4] = 2'h2;
    step(4);
    chk({pad_oe_n[4], pad_out[4], periph_in.ctrl4_master_in_line}, 3'h3);
    ctrl4_spi_config = 8'h10;
    port_e_low_pad_config = 8'h94;
    periph_out.ctrl4_master_in_line = 1'b1;
    ext_val[4] = 1'b1;
    step(4);
    chk({pad_oe_n[5], pad_out[5], periph_in.ctrl4_master_out_line}, 3'h3);
    ctrl4_mode_select = mode_two_wire;
    port_e_low_pad_config = 8'hd4;
    step(2);
    chk({pad_oe_n[5], pad_out[5]}, 2'h0);
    periph_out.ctrl4_two_wire_data = 1'b1;
    ext_val[5] = 1'b0;
    step(4);
    chk({pad_oe_n[5], periph_in.ctrl4_two_wire_data}, 2'h2);
  endtask
  task automatic t_port_b;
    port_b_low_pad_config = 4'h9;
    timer2_pin_remap = 8'h10;
    timer2_channel_output_enable = 1'b1;
    periph_out.timer2_channel1_pin = 1'b1;
    ctrl1_mode_select = mode_uart;
    step(2);
    chk({pad_oe_n[6], pad_out[6]}, 2'h1);
    timer2_channel_output_enable = 1'b0;
    step(2);
    chk({pad_oe_n[6], pad_out[6]}, 2'h0);
    timer2_channel_output_enable = 1'b1;
    timer2_pin_remap = 8'hef;
    periph_out.ctrl1_uart_transmit = 1'b1;
    step(2);
    chk({pad_oe_n[6], pad_out[6]}, 2'h1);
    ctrl1_mode_select = mode_spi;
    ctrl1_spi_config = 8'h10;
    periph_out.ctrl1_master_in_line = 1'b1;
    step(2);
    chk({pad_oe_n[6], pad_out[6]}, 2'h1);
    ctrl1_spi_config = 8'hef;
    step(2);
    chk({pad_oe_n[6], pad_out[6]}, 2'h0);
    ctrl1_mode_select = mode_two_wire;
    port_b_low_pad_config = 4'hd;
    step(2);
    chk({pad_oe_n[6], pad_out[6]}, 2'h0);
    periph_out.ctrl1_two_wire_data = 1'b1;
    ext_val[6] = 1'b1;
    step(4);
    chk({pad_oe_n[6], periph_in.ctrl1_two_wire_data}, 2'h3);
    chk(periph_in.timer2_channel1_pin, 1'b1);
  endtask
  task automatic t_timer1;
    port_a_high_pad_config[11:8] = 4'h9;
    timer1_channel_output_enable = 1'b1;
    periph_out.timer1_channel3_pin = 1'b1;
    ext_val[2] = 1'b1;
    step(4);
    chk({pad_oe_n[2], pad_out[2], periph_in.timer1_channel3_pin}, 3'h3);
    port_a_high_pad_config[11:8] = 4'h4;
    timer1_channel_output_enable = 1'b0;
    step(4);
    chk({pad_oe_n[2], periph_in.timer1_channel3_pin}, 2'h3);
  endtask
  task automatic t_irq;
    port_a_high_pad_config = 12'h444;
    port_b_low_pad_config = 4'h4;
    port_e_low_pad_config = 8'h44;
    for (int i = 0; i < 7; i++) begin
      ext_val = 7'h01 << i;
      ext_irq_c_pin_select = 3'(i);
      ext_irq_d_pin_select = 3'(6 - i);
      step(4);
      chk({external_interrupt_c, external_interrupt_d}, {1'b1, i == 3});
    end
    ext_irq_c_pin_select = 3'h7;
    ext_val = 7'h7f;
    step(4);
    chk(external_interrupt_c, 1'b0);
  endtask
  task automatic t_boot(input logic pin);
    ext_val[1] = pin; // boot pin held through external reset
    external_reset_n = 1'b0;
    step(6);
    chk(boot_to_monitor, !pin);
    external_reset_n = 1'b1;
    step(12);
    ext_val[1] = !pin;
    step(4);
    chk(boot_to_monitor, !pin);
  endtask
  // main sequence
  initial begin
    step(8);
    rst_b = 1'b1;
    step(3);
    t_trace_pads();
    t_ctrl3();
    t_ctrl4();
    t_port_b();
    t_timer1();
    t_irq();
    t_boot(1'b0);
    t_boot(1'b1);
    report_and_stop();
  end
  // watchdog well beyond the roughly 150 cycles the tests need
  initial begin
    #50us;
    fail_count++;
    report_and_stop();
  end
endmodule // pad_function_select_tb
`default_nettype wire
